// >>> testbench/host_pin_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_pin_model (
  // Device side
  input  wire logic dev_one_in,
  input  wire logic one_oe_in,
  input  wire logic dev_two_in,
  input  wire logic two_oe_in,
  // Scenario control
  input  wire logic clk_run_in,
  input  wire logic trig_go_in,
  // Resolved pins
  output logic      pin_one_out,
  output logic      pin_two_out
);
  // ==========================================================
  // Link clock and trigger
  logic lclk_reg = 1'b0;
  logic trig_reg = 1'b0;
  // Clock stands low between frames
  always #80 lclk_reg = clk_run_in & ~lclk_reg;
  // Single pulse, so the low time and rate limit hold trivially
  always @(posedge trig_go_in) begin
    trig_reg = 1'b1;
    #25000;
    trig_reg = 1'b0;
  end
  assign pin_one_out = one_oe_in ? dev_one_in : lclk_reg;
  assign pin_two_out = two_oe_in ? dev_two_in : trig_reg;
endmodule // host_pin_model
`default_nettype wire

// >>> testbench/sensor_fifo_irq_status_tb.sv
`timescale 1ns/10ps
`default_nettype none
module sensor_fifo_irq_status_tb;
  // ==========================================================
  // Harness
  logic        mclk_in = 1'b0, rstn_in = 1'b0, wr = 1'b0, rd = 1'b0, qr = 1'b0, bu = 1'b0;
  logic        tick = 1'b0, sv = 1'b0, mo = 1'b0, st = 1'b0, crun = 1'b0, tgo = 1'b0;
  logic        pend = 1'b0, p1, p2, p1o, p1e, p2o, p2e, sel, tk, req;
  logic [7:0]  ad = 8'h00, wd = 8'h00, rdat;
  logic [2:0]  frate;
  logic [11:0] d [4] = '{default: 12'h000};
  logic [7:0]  exp_q [$];
  int          error_cnt = 0, cmp_count = 0, seed = 91, reqs = 0, ticks = 0;
  initial forever #10 mclk_in = ~mclk_in;
  sensor_fifo_irq_status #(.DEPTH(8)) dut_u (.mclk_in(mclk_in), .rstn_in(rstn_in),
    .reg_addr_in(ad), .reg_wr_in(wr), .reg_wdata_in(wd), .reg_rd_in(rd),
    .queue_rd_in(qr), .burst_active_in(bu), .reg_rdata_out(rdat), .rate_tick_in(tick),
    .sample_valid_in(sv), .x_in(d[0]), .y_in(d[1]), .z_in(d[2]), .temp_in(d[3]),
    .motion_event_in(mo), .still_event_in(st), .sample_req_out(req),
    .filter_rate_out(frate), .event_pin_one_in(p1), .event_pin_one_out(p1o),
    .event_pin_one_oe_out(p1e), .event_pin_two_in(p2), .event_pin_two_out(p2o),
    .event_pin_two_oe_out(p2e), .outside_clock_select_out(sel),
    .outside_clock_tick_out(tk));
  host_pin_model host_u (.dev_one_in(p1o), .one_oe_in(p1e), .dev_two_in(p2o),
    .two_oe_in(p2e), .clk_run_in(crun), .trig_go_in(tgo), .pin_one_out(p1),
    .pin_two_out(p2));
  task automatic cy(int n = 1);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic chk(string nm, logic [7:0] s, logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic w(logic [7:0] a, logic [7:0] v);
    cy();
    ad = a;
    wd = v;
    wr = 1'b1;
    cy();
    wr = 1'b0;
  endtask
  // Expected byte is queued here, compared by the monitor
  task automatic r(logic [7:0] a, logic [7:0] e, logic isq = 1'b0);
    cy();
    ad = a;
    bu = 1'b1;
    rd = !isq;
    qr = isq;
    exp_q.push_back(e);
    cy();
    rd = 1'b0;
    qr = 1'b0;
  endtask
  task automatic qe(int t);
    r(8'h00, d[t][7:0], 1'b1);
    r(8'h00, {t[1:0], {2{d[t][11]}}, d[t][11:8]}, 1'b1);
  endtask
  task automatic eb;
    cy();
    bu = 1'b0;
    cy(3);
  endtask
  task automatic pulse(ref logic s);
    cy();
    s = 1'b1;
    cy();
    s = 1'b0;
  endtask
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ==========================================================
  // Monitor and watchdog
  always @(posedge mclk_in) pend <= rd | qr;
  always @(negedge mclk_in) begin
    if (pend) chk("rdata", rdat, exp_q.pop_front());
    if (req === 1'b1) reqs++;
    if (tk === 1'b1) ticks++;
  end
  initial begin
    #400000;
    error_cnt++;
    give_verdict();
  end
  // ==========================================================
  // Scenarios
  initial begin
    cy(4);
    rstn_in = 1'b1;
    chk("oe", {6'h00, p1e, p2e}, 8'h00);
    r(8'h29, 8'h80);
    r(8'h0B, 8'h00);
    eb();
    d[0] = 12'($random(seed));
    w(8'h29, d[0][7:0]);
    r(8'h29, d[0][7:0]);
    w(8'h29, 8'h02);
    pulse(tick);
    cy(6);
    chk("req", reqs[7:0], 8'h01);
    w(8'h28, 8'h06);
    w(8'h2A, 8'h03);
    w(8'h2B, 8'h84);
    foreach (d[i]) d[i] = 12'($random(seed));
    pulse(sv);
    cy(8);
    chk("pins", {4'h0, p1e, p1, p2e, p2}, 8'h0E);
    r(8'h0B, 8'h07);
    eb();
    for (int i = 0; i < 4; i++) qe(i);
    r(8'h00, 8'h00, 1'b1);
    r(8'h00, 8'h00, 1'b1);
    eb();
    r(8'h0B, 8'h01);
    eb();
    r(8'h0E, d[0][7:0]);
    eb();
    r(8'h0B, 8'h00);
    eb();
    chk("pins", {4'h0, p1e, p1, p2e, p2}, 8'h0B);
    w(8'h28, 8'h01);
    repeat (3) begin
      pulse(sv);
      cy(5);
    end
    r(8'h0B, 8'h0F);
    eb();
    qe(0);
    eb();
    r(8'h0B, 8'h07);
    eb();
    for (int i = 1; i < 8; i++) qe(i % 3);
    eb();
    pulse(sv);
    cy(5);
    w(8'h28, 8'h00);
    cy(3);
    r(8'h0B, 8'h01);
    r(8'h00, 8'h00, 1'b1);
    r(8'h00, 8'h00, 1'b1);
    eb();
    w(8'h2B, 8'h30);
    pulse(mo);
    pulse(st);
    cy(4);
    chk("pin2", {6'h00, p2e, p2}, 8'h03);
    r(8'h0B, 8'h31);
    eb();
    r(8'h0B, 8'h01);
    eb();
    chk("pin2", {6'h00, p2e, p2}, 8'h02);
    r(8'h0F, {{4{d[0][11]}}, d[0][11:8]});
    r(8'h09, d[1][11:4]);
    pulse(sv);
    cy(3);
    r(8'h0B, 8'h00);
    eb();
    r(8'h0B, 8'h01);
    eb();
    w(8'h28, 8'h0A);
    repeat (3) begin
      pulse(sv);
      cy(5);
    end
    r(8'h0B, 8'h0B);
    qe(1);
    eb();
    w(8'h28, 8'h00);
    w(8'h2D, 8'h40);
    cy(3);
    chk("oe1", {7'h00, p1e}, 8'h00);
    chk("sel", {7'h00, sel}, 8'h01);
    crun = 1'b1;
    #600;
    crun = 1'b0;
    cy(6);
    chk("ticks", ticks[7:0], 8'h04);
    w(8'h2C, 8'h1B);
    cy(3);
    chk("oe2", {7'h00, p2e}, 8'h00);
    reqs = 0;
    tgo = 1'b1;
    pulse(tick);
    cy(2600);
    chk("req", reqs[7:0], 8'h01);
    chk("rate", {5'h00, frate}, 8'h03);
    give_verdict();
  end
endmodule // sensor_fifo_irq_status_tb
`default_nettype wire

// >>> testbench/sensor_irq_props.sv
`timescale 1ns/10ps
`default_nettype none
module sensor_irq_props
  import sensor_irq_pkg::*;
(
  // Clock and reset
  input wire logic       mclk_in,
  input wire logic       rstn_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic       reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic       reg_rd_in,
  input wire logic       queue_rd_in,
  input wire logic       burst_active_in,
  input wire logic [7:0] reg_rdata_out,
  // Pins and pacing
  input wire logic       sample_req_out,
  input wire logic [2:0] filter_rate_out,
  input wire logic       event_pin_one_in,
  input wire logic       event_pin_one_oe_out,
  input wire logic       outside_clock_select_out,
  input wire logic       outside_clock_tick_out
);
  // ==========================================================
  // Read tracking
  wire logic       flag_rd = reg_rd_in && reg_addr_in == ADDR_EVENT_FLAGS;
  wire logic       data_rd = reg_rd_in && (reg_addr_in inside
    {[ADDR_DATA8_X:ADDR_DATA8_Z], [ADDR_DATA16_LO:ADDR_DATA16_HI]});
  wire logic       wd_clk  = reg_wdata_in[PWR_CLK_SEL];
  wire logic [2:0] wd_rate = reg_wdata_in[2:0];
  logic [1:0]      dr_q;
  // Two stages so a flags read never races the clear it checks
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) dr_q <= 2'b00;
    else dr_q <= burst_active_in ? {dr_q[0], dr_q[0] | data_rd} : 2'b00;
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);
  // ==========================================================
  // Properties
  rdata_hold_a: assert property (!reg_rd_in && !queue_rd_in |=> $stable(reg_rdata_out))
    else $error("read byte changed without a read");
  flags_top_a: assert property (flag_rd |=> reg_rdata_out[7:6] == 2'b00)
    else $error("unused flag bits set");
  ready_hold_a: assert property (flag_rd && dr_q[1] |=> !reg_rdata_out[FLAG_NEW_SAMPLE])
    else $error("new sample flag seen during data read");
  clk_float_a: assert property (outside_clock_select_out |=> !event_pin_one_oe_out)
    else $error("clock input pin still driven");
  tick_sel_a: assert property (outside_clock_tick_out |-> outside_clock_select_out)
    else $error("clock tick without clock select");
  tick_edge_a: assert property ($rose(event_pin_one_in) && outside_clock_select_out
    |-> ##[1:5] outside_clock_tick_out) else $error("clock edge missed");
  filt_rate_a: assert property (reg_wr_in && reg_addr_in == ADDR_FILTER_CONTROL_REG
    |-> ##2 filter_rate_out == $past(wd_rate, 2)) else $error("filter rate not updated");
  clk_sel_a: assert property (reg_wr_in && reg_addr_in == ADDR_POWER_CONTROL_REG
    |-> ##2 outside_clock_select_out == $past(wd_clk, 2)) else $error("clock select wrong");
  req_pulse_a: assert property (sample_req_out |=> !sample_req_out)
    else $error("sample request longer than one cycle");
endmodule // sensor_irq_props
bind sensor_fifo_irq_status sensor_irq_props props_u (.mclk_in(mclk_in), .rstn_in(rstn_in),
  .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in),
  .reg_rd_in(reg_rd_in), .queue_rd_in(queue_rd_in), .burst_active_in(burst_active_in),
  .reg_rdata_out(reg_rdata_out), .sample_req_out(sample_req_out),
  .filter_rate_out(filter_rate_out), .event_pin_one_in(event_pin_one_in),
  .event_pin_one_oe_out(event_pin_one_oe_out),
  .outside_clock_select_out(outside_clock_select_out),
  .outside_clock_tick_out(outside_clock_tick_out));
`default_nettype wire

// >>> verilog/queue_if.sv
`timescale 1ns/10ps
`default_nettype none
interface queue_if #(parameter int DEPTH = 512, parameter int WIDTH = 16);
  logic                     push;
  logic [WIDTH-1:0]         push_data;
  logic                     pop;
  logic                     flush;
  logic                     keep_oldest;
  logic [WIDTH-1:0]         head_data;
  logic [$clog2(DEPTH):0]   count;
  logic                     full;
  logic                     empty;
  modport ctrl (output push, push_data, pop, flush, keep_oldest,
                input head_data, count, full, empty);
  modport store (input push, push_data, pop, flush, keep_oldest,
                 output head_data, count, full, empty);
endinterface
`default_nettype wire

// >>> verilog/sample_queue.sv
`timescale 1ns/10ps
`default_nettype none
module sample_queue #(
  parameter int DEPTH = 512,
  parameter int WIDTH = 16
) (
  // Clock and reset
  input  wire logic mclk_in,
  input  wire logic rstn_in,
  // Queue port
  queue_if.store    q
);
  localparam int PW = $clog2(DEPTH);

  if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
    $error("sample_queue: DEPTH must be a power of two, at least 4");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic [PW:0]      count_reg;

  wire do_pop   = q.pop && !q.empty;
  // Full stream queue drops its oldest entry to make room
  wire evict    = q.push && q.full && !q.keep_oldest && !do_pop;
  wire do_write = q.push && (!q.full || !q.keep_oldest || do_pop);
  wire adv_rd   = do_pop || evict;
  wire [PW:0] count_next = count_reg + (PW+1)'(do_write && !adv_rd)
                                    - (PW+1)'(adv_rd && !do_write);

  assign q.head_data = q.empty ? '0 : mem[rd_ptr_reg];
  assign q.count     = count_reg;
  assign q.full      = (count_reg == (PW+1)'(DEPTH));
  assign q.empty     = (count_reg == '0);

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else if (q.flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + PW'(do_write);
      rd_ptr_reg <= rd_ptr_reg + PW'(adv_rd);
      count_reg  <= count_next;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (do_write && !q.flush) begin
      mem[wr_ptr_reg] <= q.push_data;
    end
  end
endmodule // sample_queue
`default_nettype wire

// >>> verilog/sensor_fifo_irq_status.sv
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Queue reads come as byte pairs; reads past an empty queue return zero.
// - Each sample set enters as X, Y, Z, then temperature when enabled.
// - A set that does not fit may be stored only in part.
// - Each entry read frees one entry; partial sets may stay.
// - Two map registers route sources; each pin ORs its mapped sources.
// - A pin with nothing mapped, or in reset, floats.
// - Active pins drive high unless the map's polarity bit is set.
// - Reading the event flags clears motion and stillness.
// - Reading any sample data register clears the new-sample flag.
// - Queue flags clear when enough entries are read.
// - Clock-select turns pin one into input; trigger-select turns pin two.
// - Motion sets flag bit 4, stillness sets flag bit 5.
// - Flag bit 0 marks a new valid sample.
// - New-sample flag held zero during data reads, set after them.
// - Flag bit 2 while stored count reaches the nine-bit threshold.
// - Threshold resets nonzero because zero keeps the level flag set.
// - Flag bit 1 while the queue holds an entry.
// - Flag bit 3 when data is lost to a full queue.
// - Overflow clears when a whole entry is read (high byte) or when the queue is off.
// - External trigger paces sampling; filter rate still follows the rate field.
// - Entries are 16 bits, low byte first, type in the top two bits.
// - A disabled queue stores nothing and discards its contents.
module sensor_fifo_irq_status
  import sensor_irq_pkg::*;
#(
  parameter int DEPTH = sensor_irq_pkg::QUEUE_DEPTH
) (
  // Clock and reset
  input  wire logic                                mclk_in,
  input  wire logic                                rstn_in,
  // Register access from the serial port engine
  input  wire logic [7:0]                          reg_addr_in,
  input  wire logic                                reg_wr_in,
  input  wire logic [7:0]                          reg_wdata_in,
  input  wire logic                                reg_rd_in,
  input  wire logic                                queue_rd_in,
  input  wire logic                                burst_active_in,
  output logic [7:0]                               reg_rdata_out,
  // Converter and detectors
  input  wire logic                                rate_tick_in,
  input  wire logic                                sample_valid_in,
  input  wire logic [sensor_irq_pkg::SAMPLE_W-1:0] x_in,
  input  wire logic [sensor_irq_pkg::SAMPLE_W-1:0] y_in,
  input  wire logic [sensor_irq_pkg::SAMPLE_W-1:0] z_in,
  input  wire logic [sensor_irq_pkg::SAMPLE_W-1:0] temp_in,
  input  wire logic                                motion_event_in,
  input  wire logic                                still_event_in,
  output logic                                     sample_req_out,
  output logic [2:0]                               filter_rate_out,
  // Event pins
  input  wire logic                                event_pin_one_in,
  output logic                                     event_pin_one_out,
  output logic                                     event_pin_one_oe_out,
  input  wire logic                                event_pin_two_in,
  output logic                                     event_pin_two_out,
  output logic                                     event_pin_two_oe_out,
  // Outside clock
  output logic                                     outside_clock_select_out,
  output logic                                     outside_clock_tick_out
);
  import sensor_irq_pkg::*;

  if (DEPTH < 4 || DEPTH > 512) begin : g_depth_check
    $error("sensor_fifo_irq_status: DEPTH must lie in 4..512");
  end

  localparam int CW = $clog2(DEPTH) + 1;

  // ==========================================================
  // Registers
  logic [7:0]      event_flags_reg;
  logic [7:0]      queue_level_threshold_reg;
  logic [7:0]      queue_ctl_reg;
  logic [7:0]      pin_one_source_map_reg;
  logic [7:0]      pin_two_source_map_reg;
  logic [7:0]      filter_control_reg;
  logic [7:0]      power_control_reg;
  logic [SAMPLE_W-1:0] x_reg, y_reg, z_reg, t_reg;
  seq_state_t      seq_reg, seq_next;
  logic            data_burst_reg;
  logic            ready_pending_reg;
  logic            high_byte_reg;
  logic [2:0]      one_sync_reg, two_sync_reg;

  queue_if #(.DEPTH(DEPTH), .WIDTH(ENTRY_W)) qbus ();

  sample_queue #(.DEPTH(DEPTH), .WIDTH(ENTRY_W)) u_queue (
    .mclk_in (mclk_in),
    .rstn_in (rstn_in),
    .q       (qbus.store)
  );

  // ==========================================================
  // Decoding
  wire [1:0] queue_mode  = queue_ctl_reg[QCTL_MODE_LSB +: 2];
  wire       queue_on    = (queue_mode != MODE_OFF);
  wire       temp_on     = queue_ctl_reg[QCTL_TEMP_EN];
  wire       outside_clock_select   = power_control_reg[PWR_CLK_SEL];
  wire       outside_trigger_select = filter_control_reg[FILT_TRIG_SEL];
  wire       data_addr = (reg_addr_in >= ADDR_DATA8_X && reg_addr_in <= ADDR_DATA8_Z) ||
                         (reg_addr_in >= ADDR_DATA16_LO && reg_addr_in <= ADDR_DATA16_HI);
  wire       data_rd_start  = reg_rd_in && data_addr && !data_burst_reg;
  wire       flags_rd       = reg_rd_in && (reg_addr_in == ADDR_EVENT_FLAGS);
  wire       data_rd_active = data_burst_reg || data_rd_start;
  // Pop on the high byte, so an entry is freed only when whole
  wire       entry_done = queue_rd_in && high_byte_reg;

  // ==========================================================
  // Sample set sequencer
  wire       seq_push = (seq_reg != SEQ_IDLE) && queue_on;
  logic [1:0]          seq_type;
  logic [SAMPLE_W-1:0] seq_data;
  always_comb begin
    seq_next = seq_reg;
    seq_type = TYPE_X;
    seq_data = x_reg;
    case (seq_reg)
      SEQ_IDLE: if (sample_valid_in) seq_next = SEQ_X;
      SEQ_X: begin
        seq_next = SEQ_Y;
      end
      SEQ_Y: begin
        seq_next = SEQ_Z;
        seq_type = TYPE_Y;
        seq_data = y_reg;
      end
      SEQ_Z: begin
        seq_next = temp_on ? SEQ_T : SEQ_IDLE;
        seq_type = TYPE_Z;
        seq_data = z_reg;
      end
      SEQ_T: begin
        seq_next = SEQ_IDLE;
        seq_type = TYPE_TEMP;
        seq_data = t_reg;
      end
      default: seq_next = SEQ_IDLE;
    endcase
  end

  // Each entry tried on its own, so a full queue cuts a set short
  assign qbus.push        = seq_push;
  assign qbus.push_data   = {seq_type, {2{seq_data[SAMPLE_W-1]}}, seq_data};
  assign qbus.pop         = entry_done;
  assign qbus.flush       = !queue_on;
  assign qbus.keep_oldest = (queue_mode == MODE_KEEP_OLDEST);

  // ==========================================================
  // Event flags
  wire [8:0] level_thr = {queue_ctl_reg[QCTL_LEVEL_MSB], queue_level_threshold_reg};
  wire [CW-1:0] count  = qbus.count;
  wire level_hit       = 10'(count) >= 10'(level_thr);
  // Stream loses the oldest, keep-oldest loses the newest
  wire lost_data       = seq_push && qbus.full && !entry_done;
  wire new_sample      = sample_valid_in;
  wire ready_set       = data_rd_active ? 1'b0 : (new_sample || ready_pending_reg);
  wire ready_next      = data_rd_start ? 1'b0 :
                         data_rd_active ? 1'b0 :
                         (event_flags_reg[FLAG_NEW_SAMPLE] || ready_set);
  wire over_next       = !queue_on ? 1'b0 :
                         lost_data ? 1'b1 :
                         entry_done ? 1'b0 : event_flags_reg[FLAG_OVERFLOW];
  // Set beats clear when an event meets the flag read
  wire motion_next     = motion_event_in ||
                         (event_flags_reg[FLAG_MOTION] && !flags_rd);
  wire still_next      = still_event_in ||
                         (event_flags_reg[FLAG_STILLNESS] && !flags_rd);
  wire [7:0] flags_next = {2'b00, still_next, motion_next, over_next,
                           level_hit, !qbus.empty, ready_next};

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      event_flags_reg   <= REG_ZERO;
      ready_pending_reg <= 1'b0;
      data_burst_reg    <= 1'b0;
    end else begin
      event_flags_reg   <= flags_next;
      ready_pending_reg <= data_rd_active ? (ready_pending_reg || new_sample) : 1'b0;
      data_burst_reg    <= data_rd_active && burst_active_in;
    end
  end

  // ==========================================================
  // Control registers
  wire wr_thr  = reg_wr_in && (reg_addr_in == ADDR_QUEUE_THR);
  wire wr_qctl = reg_wr_in && (reg_addr_in == ADDR_QUEUE_CTL);
  wire wr_map1 = reg_wr_in && (reg_addr_in == ADDR_PIN_ONE_MAP);
  wire wr_map2 = reg_wr_in && (reg_addr_in == ADDR_PIN_TWO_MAP);
  wire wr_filt = reg_wr_in && (reg_addr_in == ADDR_FILTER_CONTROL_REG);
  wire wr_pwr  = reg_wr_in && (reg_addr_in == ADDR_POWER_CONTROL_REG);

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      queue_level_threshold_reg <= THRESHOLD_RESET;
      queue_ctl_reg             <= REG_ZERO;
      pin_one_source_map_reg    <= REG_ZERO;
      pin_two_source_map_reg    <= REG_ZERO;
      filter_control_reg        <= FILTER_RESET;
      power_control_reg         <= REG_ZERO;
    end else begin
      if (wr_thr)  queue_level_threshold_reg <= reg_wdata_in;
      if (wr_qctl) queue_ctl_reg <= reg_wdata_in;
      if (wr_map1) pin_one_source_map_reg <= reg_wdata_in;
      if (wr_map2) pin_two_source_map_reg <= reg_wdata_in;
      if (wr_filt) filter_control_reg <= reg_wdata_in;
      if (wr_pwr)  power_control_reg <= reg_wdata_in;
    end
  end

  // ==========================================================
  // Sample capture and sequencing
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      seq_reg <= SEQ_IDLE;
      x_reg   <= '0;
      y_reg   <= '0;
      z_reg   <= '0;
      t_reg   <= '0;
    end else begin
      seq_reg <= seq_next;
      if (sample_valid_in && seq_reg == SEQ_IDLE) begin
        x_reg <= x_in;
        y_reg <= y_in;
        z_reg <= z_in;
        t_reg <= temp_in;
      end
    end
  end

  // ==========================================================
  // Read data path
  wire [ENTRY_W-1:0] hx = {{4{x_reg[SAMPLE_W-1]}}, x_reg};
  wire [ENTRY_W-1:0] hy = {{4{y_reg[SAMPLE_W-1]}}, y_reg};
  wire [ENTRY_W-1:0] hz = {{4{z_reg[SAMPLE_W-1]}}, z_reg};
  wire [ENTRY_W-1:0] ht = {{4{t_reg[SAMPLE_W-1]}}, t_reg};
  wire [3:0] didx = 4'(reg_addr_in - ADDR_DATA16_LO);
  wire [ENTRY_W-1:0] dword = (didx[2:1] == 2'd0) ? hx : (didx[2:1] == 2'd1) ? hy :
                             (didx[2:1] == 2'd2) ? hz : ht;
  wire [7:0] dbyte = didx[0] ? dword[15:8] : dword[7:0];
  // Empty queue answers zero bytes
  wire [7:0] qbyte = high_byte_reg ? qbus.head_data[15:8] : qbus.head_data[7:0];
  wire [7:0] rd_mux =
      queue_rd_in ? qbyte :
      (reg_addr_in == ADDR_DATA8_X)      ? x_reg[11:4] :
      (reg_addr_in == ADDR_DATA8_X + 8'h01) ? y_reg[11:4] :
      (reg_addr_in == ADDR_DATA8_Z)      ? z_reg[11:4] :
      (reg_addr_in == ADDR_EVENT_FLAGS)  ? event_flags_reg :
      (reg_addr_in >= ADDR_DATA16_LO && reg_addr_in <= ADDR_DATA16_HI) ? dbyte :
      (reg_addr_in == ADDR_QUEUE_CTL)    ? queue_ctl_reg :
      (reg_addr_in == ADDR_QUEUE_THR)    ? queue_level_threshold_reg :
      (reg_addr_in == ADDR_PIN_ONE_MAP)  ? pin_one_source_map_reg :
      (reg_addr_in == ADDR_PIN_TWO_MAP)  ? pin_two_source_map_reg :
      (reg_addr_in == ADDR_FILTER_CONTROL_REG)   ? filter_control_reg :
      (reg_addr_in == ADDR_POWER_CONTROL_REG)    ? power_control_reg : REG_ZERO;

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      reg_rdata_out <= REG_ZERO;
      high_byte_reg <= 1'b0;
    end else begin
      if (reg_rd_in || queue_rd_in) reg_rdata_out <= rd_mux;
      // Byte phase restarts with every burst
      if (!burst_active_in) high_byte_reg <= 1'b0;
      else if (queue_rd_in) high_byte_reg <= !high_byte_reg;
    end
  end

  // ==========================================================
  // Pins
  wire [NUM_FLAGS-1:0] flags6 = event_flags_reg[NUM_FLAGS-1:0];
  wire one_any  = |pin_one_source_map_reg[NUM_FLAGS-1:0];
  wire two_any  = |pin_two_source_map_reg[NUM_FLAGS-1:0];
  wire one_hit  = |(flags6 & pin_one_source_map_reg[NUM_FLAGS-1:0]);
  wire two_hit  = |(flags6 & pin_two_source_map_reg[NUM_FLAGS-1:0]);
  // Trigger edge only on the synchronised pair, never the first stage
  wire trig_rise = outside_trigger_select && two_sync_reg[1] && !two_sync_reg[2];
  wire clk_rise  = outside_clock_select && one_sync_reg[1] && !one_sync_reg[2];

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      event_pin_one_out        <= 1'b0;
      event_pin_one_oe_out     <= 1'b0;
      event_pin_two_out        <= 1'b0;
      event_pin_two_oe_out     <= 1'b0;
      one_sync_reg             <= 3'b000;
      two_sync_reg             <= 3'b000;
      sample_req_out           <= 1'b0;
      filter_rate_out          <= 3'b000;
      outside_clock_select_out <= 1'b0;
      outside_clock_tick_out   <= 1'b0;
    end else begin
      event_pin_one_out    <= one_hit ^ pin_one_source_map_reg[MAP_ACTIVE_LOW];
      event_pin_one_oe_out <= one_any && !outside_clock_select;
      event_pin_two_out    <= two_hit ^ pin_two_source_map_reg[MAP_ACTIVE_LOW];
      event_pin_two_oe_out <= two_any && !outside_trigger_select;
      one_sync_reg <= {one_sync_reg[1:0], event_pin_one_in};
      two_sync_reg <= {two_sync_reg[1:0], event_pin_two_in};
      // Trigger pulse width is the driver's duty, not checked here
      sample_req_out <= outside_trigger_select ? trig_rise : rate_tick_in;
      filter_rate_out <= filter_control_reg[FILT_RATE_LSB +: 3];
      outside_clock_select_out <= outside_clock_select;
      outside_clock_tick_out   <= clk_rise;
    end
  end
endmodule // sensor_fifo_irq_status
`default_nettype wire

// >>> verilog/sensor_irq_pkg.sv
`default_nettype none
package sensor_irq_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] ADDR_DATA8_X    = 8'h08;
  localparam logic [7:0] ADDR_DATA8_Z    = 8'h0A;
  localparam logic [7:0] ADDR_EVENT_FLAGS = 8'h0B;
  localparam logic [7:0] ADDR_DATA16_LO  = 8'h0E;
  localparam logic [7:0] ADDR_DATA16_HI  = 8'h15;
  localparam logic [7:0] ADDR_QUEUE_CTL  = 8'h28;
  localparam logic [7:0] ADDR_QUEUE_THR  = 8'h29;
  localparam logic [7:0] ADDR_PIN_ONE_MAP = 8'h2A;
  localparam logic [7:0] ADDR_PIN_TWO_MAP = 8'h2B;
  localparam logic [7:0] ADDR_FILTER_CONTROL_REG = 8'h2C;
  localparam logic [7:0] ADDR_POWER_CONTROL_REG  = 8'h2D;
  // ==========================================================
  // Field positions
  localparam int FLAG_NEW_SAMPLE = 0;
  localparam int FLAG_QUEUE_READY = 1;
  localparam int FLAG_QUEUE_LEVEL = 2;
  localparam int FLAG_OVERFLOW   = 3;
  localparam int FLAG_MOTION     = 4;
  localparam int FLAG_STILLNESS  = 5;
  localparam int NUM_FLAGS       = 6;
  localparam int MAP_ACTIVE_LOW  = 7;
  localparam int QCTL_MODE_LSB   = 0;
  localparam int QCTL_TEMP_EN    = 2;
  localparam int QCTL_LEVEL_MSB  = 3;
  localparam int FILT_RATE_LSB   = 0;
  localparam int FILT_TRIG_SEL   = 3;
  localparam int PWR_CLK_SEL     = 6;
  // ==========================================================
  // Reset values and encodings
  localparam logic [7:0] THRESHOLD_RESET = 8'h80;
  localparam logic [7:0] REG_ZERO        = 8'h00;
  localparam logic [7:0] FILTER_RESET    = 8'h13;
  localparam logic [1:0] MODE_OFF        = 2'h0;
  localparam logic [1:0] MODE_KEEP_OLDEST = 2'h1;
  localparam logic [1:0] TYPE_X          = 2'h0;
  localparam logic [1:0] TYPE_Y          = 2'h1;
  localparam logic [1:0] TYPE_Z          = 2'h2;
  localparam logic [1:0] TYPE_TEMP       = 2'h3;
  localparam int QUEUE_DEPTH = 512;
  localparam int ENTRY_W     = 16;
  localparam int SAMPLE_W    = 12;
  typedef enum logic [4:0] {
    SEQ_IDLE = 5'b0_0001,
    SEQ_X    = 5'b0_0010,
    SEQ_Y    = 5'b0_0100,
    SEQ_Z    = 5'b0_1000,
    SEQ_T    = 5'b1_0000
  } seq_state_t;
endpackage
`default_nettype wire
